// *** lrs_pkg.sv ***
// shared opcodes, field layout, reset values and types of the command block
package lrs_pkg;

	// command opcodes, taken from data bits 7..0
	localparam logic [7:0] OPC_MEMORY_WRITE   = 8'h5C;
	localparam logic [7:0] OPC_MEMORY_READ    = 8'h5D;
	localparam logic [7:0] OPC_PARTIAL_ENTER  = 8'hA8;
	localparam logic [7:0] OPC_PARTIAL_EXIT   = 8'hA9;
	localparam logic [7:0] OPC_AREA_SCROLL    = 8'hAA;
	localparam logic [7:0] OPC_SCROLL_START   = 8'hAB;
	localparam logic [7:0] OPC_OSCILLATOR_ON  = 8'hD1;
	localparam logic [7:0] OPC_RMW_ENTER      = 8'hE0;
	localparam logic [7:0] OPC_RMW_EXIT       = 8'hEE;

	// field positions and widths
	localparam int         BUS_W          = 16;
	localparam int         ADDR_W         = 8;
	localparam int         BLK_W          = 6;
	localparam int         MODE_W         = 2;
	localparam int         OPC_MSB        = 7;
	localparam int         BLK_MSB        = 5;
	localparam int         MODE_MSB       = 1;
	localparam int         LINE_BLK_LSB   = 2;
	localparam int         LINE_W         = 8;

	// block numbering
	localparam logic [5:0] LAST_RAM_BLOCK = 6'h29;
	localparam logic [6:0] ONE_BLOCK      = 7'h01;

	// synchroniser vector: [19] clock source, [18] select, [17] wr_n,
	// [16] rd_n, [15:0] data
	localparam int         SYNC_W         = 20;
	localparam logic [19:0] SYNC_RST      = 20'h30000;

	// reset values
	localparam logic [5:0]  RST_BLOCK     = 6'h00;
	localparam logic [7:0]  RST_ADDR      = 8'h00;
	localparam logic [15:0] RST_DATA      = 16'h0000;

	typedef enum logic [1:0] {
		LRS_SCROLL_CENTER,
		LRS_SCROLL_TOP,
		LRS_SCROLL_BOTTOM,
		LRS_SCROLL_WHOLE
	} lrs_scroll_mode_t;

	typedef enum logic [3:0] {
		LRS_IDLE,
		LRS_WRITE,
		LRS_READ,
		LRS_RMW,
		LRS_PTL_START,
		LRS_PTL_END,
		LRS_ASC_TOP,
		LRS_ASC_BOTTOM,
		LRS_ASC_COUNT,
		LRS_ASC_MODE,
		LRS_SCS_BLOCK
	} lrs_state_t;

	// mode field to scroll type
	function automatic lrs_scroll_mode_t lrs_decode_mode(
		input logic [1:0] field
	);
		case (field)
			2'h0: lrs_decode_mode = LRS_SCROLL_CENTER;
			2'h1: lrs_decode_mode = LRS_SCROLL_TOP;
			2'h2: lrs_decode_mode = LRS_SCROLL_BOTTOM;
			default: lrs_decode_mode = LRS_SCROLL_WHOLE;
		endcase
	endfunction

endpackage

// *** lrs_sync3.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module lrs_sync3 #(
	parameter int              W   = 1,
	parameter logic [W-1:0]    RST = '0
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          resetn,
	// pins and filtered result
	input  wire logic [W-1:0]  din,
	output logic      [W-1:0]  dout
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] differ;
	logic [W-1:0] next_dout;

	// a bit follows only when stages two and three agree
	assign differ    = s2 ^ s3;
	assign next_dout = (~differ & s3) | (differ & dout);

	// shift chain and filtered output
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1   <= RST;
			s2   <= RST;
			s3   <= RST;
			dout <= RST;
		end else begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			dout <= next_dout;
		end
	end

endmodule

// *** lrs_addr_gen.sv ***
// page and column address counters with window wrap
`timescale 1ns/10ps
module lrs_addr_gen
	import lrs_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// control
	input  wire logic              load,
	input  wire logic              step,
	input  wire logic              page_dir,
	// window
	input  wire logic [ADDR_W-1:0] page_start,
	input  wire logic [ADDR_W-1:0] page_end,
	input  wire logic [ADDR_W-1:0] col_start,
	input  wire logic [ADDR_W-1:0] col_end,
	// counters
	output logic      [ADDR_W-1:0] page,
	output logic      [ADDR_W-1:0] col
);

	logic [ADDR_W-1:0] page_inc;
	logic [ADDR_W-1:0] col_inc;
	logic              page_last;
	logic              col_last;
	logic [ADDR_W-1:0] next_page;
	logic [ADDR_W-1:0] next_col;

	// increment with wrap to window start
	assign page_last = (page == page_end);
	assign col_last  = (col == col_end);
	assign page_inc  = page_last ? page_start : page + 8'h01;
	assign col_inc   = col_last ? col_start : col + 8'h01;

	// scan axis select
	always_comb begin
		next_page = page;
		next_col  = col;
		if (load) begin
			next_page = page_start;
			next_col  = col_start;
		end else if (step && page_dir) begin
			next_page = page_inc;
			if (page_last)
				next_col = col_inc;
		end else if (step) begin
			next_col = col_inc;
			if (col_last)
				next_page = page_inc;
		end
	end

	// counter registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			page <= RST_ADDR;
			col  <= RST_ADDR;
		end else begin
			page <= next_page;
			col  <= next_col;
		end
	end

endmodule

// *** lrs_cmd_core.sv ***
// command decoder for display memory access, partial display and scroll
`timescale 1ns/10ps
module lrs_cmd_core
	import lrs_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// host parallel bus pins
	input  wire logic                   cmd_data_select,
	input  wire logic                   wr_n,
	input  wire logic                   rd_n,
	input  wire logic [BUS_W-1:0]       bus_din,
	output logic      [BUS_W-1:0]       bus_dout,
	output logic                        bus_oe,
	// clock source strap pin
	input  wire logic                   clock_source_select,
	// access window from the window commands
	input  wire logic [ADDR_W-1:0]      page_start,
	input  wire logic [ADDR_W-1:0]      page_end,
	input  wire logic [ADDR_W-1:0]      col_start,
	input  wire logic [ADDR_W-1:0]      col_end,
	input  wire logic                   scan_page_dir,
	// display RAM port
	output logic      [ADDR_W-1:0]      ram_page,
	output logic      [ADDR_W-1:0]      ram_col,
	output logic                        ram_we,
	output logic      [BUS_W-1:0]       ram_wdata,
	output logic                        ram_re,
	input  wire logic [BUS_W-1:0]       ram_rdata,
	// display timing
	input  wire logic                   frame_start,
	input  wire logic [LINE_W-1:0]      line_index,
	input  wire logic [BLK_W-1:0]       last_disp_block,
	// oscillator
	output logic                        osc_enable,
	// partial display
	output logic                        partial_active,
	output logic      [BLK_W-1:0]       partial_start,
	output logic      [BLK_W-1:0]       partial_end,
	output logic                        display_off_out_n,
	output logic                        common_nonselect_level,
	output logic                        segment_pos_level,
	output logic                        segment_neg_level,
	output logic                        frame_polarity,
	// area scroll
	output logic      [BLK_W-1:0]       scroll_top,
	output logic      [BLK_W-1:0]       scroll_bottom,
	output logic      [BLK_W-1:0]       scroll_count,
	output lrs_scroll_mode_t            scroll_mode,
	output logic      [BLK_W-1:0]       scroll_start,
	output logic      [BLK_W-1:0]       ram_block
);

	import lrs_pkg::*;

	logic [SYNC_W-1:0] pins_f;
	logic              cls_f;
	logic              sel_f;
	logic              wr_n_f;
	logic              rd_n_f;
	logic [BUS_W-1:0]  din_f;
	logic              wr_n_q;
	logic              rd_n_q;
	lrs_state_t        state;
	lrs_state_t        next_state;
	logic              advance;
	logic              re_d;

	// all host pins come from outside the clock domain
	lrs_sync3 #(
		.W   (SYNC_W),
		.RST (SYNC_RST)
	) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.din    ({clock_source_select, cmd_data_select, wr_n, rd_n,
		          bus_din}),
		.dout   (pins_f)
	);

	// synchronised pin fields
	assign cls_f  = pins_f[19];
	assign sel_f  = pins_f[18];
	assign wr_n_f = pins_f[17];
	assign rd_n_f = pins_f[16];
	assign din_f  = pins_f[BUS_W-1:0];

	// strobe edges and cycle classes
	logic       wr_rise;
	logic       rd_fall;
	logic       rd_rise;
	logic       cmd_strobe;
	logic       data_strobe;
	logic [7:0] opcode;
	logic [5:0] blk;
	assign wr_rise     = wr_n_f & ~wr_n_q;
	assign rd_fall     = ~rd_n_f & rd_n_q;
	assign rd_rise     = rd_n_f & ~rd_n_q;
	assign cmd_strobe  = wr_rise & ~sel_f;
	assign data_strobe = wr_rise & sel_f;
	assign opcode      = din_f[OPC_MSB:0];
	assign blk         = din_f[BLK_MSB:0];

	// opcode decode
	logic is_mem_write;
	logic is_mem_read;
	logic is_rmw_enter;
	logic is_ptl_enter;
	logic is_ptl_exit;
	logic is_asc_set;
	logic is_scs;
	logic is_osc_on;
	assign is_mem_write = cmd_strobe & (opcode == OPC_MEMORY_WRITE);
	assign is_mem_read  = cmd_strobe & (opcode == OPC_MEMORY_READ);
	assign is_rmw_enter = cmd_strobe & (opcode == OPC_RMW_ENTER);
	assign is_ptl_enter = cmd_strobe & (opcode == OPC_PARTIAL_ENTER);
	assign is_ptl_exit  = cmd_strobe & (opcode == OPC_PARTIAL_EXIT);
	assign is_asc_set   = cmd_strobe & (opcode == OPC_AREA_SCROLL);
	assign is_scs       = cmd_strobe & (opcode == OPC_SCROLL_START);
	assign is_osc_on    = cmd_strobe & (opcode == OPC_OSCILLATOR_ON);

	// command sequencer: every command byte leaves the current mode
	always_comb begin
		next_state = state;
		if (cmd_strobe) begin
			case (opcode)
				OPC_MEMORY_WRITE:  next_state = LRS_WRITE;
				OPC_MEMORY_READ:   next_state = LRS_READ;
				OPC_RMW_ENTER:     next_state = LRS_RMW;
				OPC_PARTIAL_ENTER: next_state = LRS_PTL_START;
				OPC_AREA_SCROLL:   next_state = LRS_ASC_TOP;
				OPC_SCROLL_START:  next_state = LRS_SCS_BLOCK;
				default:           next_state = LRS_IDLE;
			endcase
		end else if (data_strobe) begin
			case (state)
				LRS_PTL_START:  next_state = LRS_PTL_END;
				LRS_PTL_END:    next_state = LRS_IDLE;
				LRS_ASC_TOP:    next_state = LRS_ASC_BOTTOM;
				LRS_ASC_BOTTOM: next_state = LRS_ASC_COUNT;
				LRS_ASC_COUNT:  next_state = LRS_ASC_MODE;
				LRS_ASC_MODE:   next_state = LRS_IDLE;
				LRS_SCS_BLOCK:  next_state = LRS_IDLE;
				default:        next_state = state;
			endcase
		end
	end

	// memory access qualifiers
	logic addr_load;
	logic stream_rd;
	logic wr_issue;
	logic rd_issue;
	logic rd_advance;
	assign addr_load  = is_mem_write | is_mem_read | is_rmw_enter;
	assign stream_rd  = (state == LRS_READ) | (state == LRS_RMW);
	assign wr_issue   = data_strobe &
	                    ((state == LRS_WRITE) | (state == LRS_RMW));
	assign rd_issue   = rd_fall & sel_f & stream_rd;
	assign rd_advance = rd_rise & sel_f & (state == LRS_READ);

	// address counters step one cycle after the access
	lrs_addr_gen u_addr (
		.clk        (clk),
		.resetn     (resetn),
		.load       (addr_load),
		.step       (advance),
		.page_dir   (scan_page_dir),
		.page_start (page_start),
		.page_end   (page_end),
		.col_start  (col_start),
		.col_end    (col_end),
		.page       (ram_page),
		.col        (ram_col)
	);

	// sequencer, edge history and RAM strobes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state   <= LRS_IDLE;
			wr_n_q  <= 1'b1;
			rd_n_q  <= 1'b1;
			advance <= 1'b0;
			ram_we  <= 1'b0;
			ram_re  <= 1'b0;
			re_d    <= 1'b0;
		end else begin
			state   <= next_state;
			wr_n_q  <= wr_n_f;
			rd_n_q  <= rd_n_f;
			advance <= wr_issue | rd_advance;
			ram_we  <= wr_issue;
			ram_re  <= rd_issue;
			re_d    <= ram_re;
		end
	end

	// write data and read data toward the host
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ram_wdata <= RST_DATA;
			bus_dout  <= RST_DATA;
			bus_oe    <= 1'b0;
		end else begin
			if (wr_issue)
				ram_wdata <= din_f;
			if (re_d)
				bus_dout <= ram_rdata;
			bus_oe <= ~rd_n_f & sel_f & stream_rd;
		end
	end

	// oscillator, honoured only with internal clock source selected
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			osc_enable <= 1'b0;
		else if (is_osc_on && cls_f)
			osc_enable <= 1'b1;
	end

	// partial display range
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			partial_active <= 1'b0;
			partial_start  <= RST_BLOCK;
			partial_end    <= RST_BLOCK;
		end else if (is_ptl_exit) begin
			partial_active <= 1'b0;
		end else if (data_strobe && state == LRS_PTL_START) begin
			partial_start  <= blk;
		end else if (data_strobe && state == LRS_PTL_END) begin
			partial_end    <= blk;
			partial_active <= 1'b1;
		end
	end

	// area scroll parameters
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scroll_top    <= RST_BLOCK;
			scroll_bottom <= RST_BLOCK;
			scroll_count  <= RST_BLOCK;
			scroll_mode   <= LRS_SCROLL_CENTER;
			scroll_start  <= RST_BLOCK;
		end else if (data_strobe) begin
			case (state)
				LRS_ASC_TOP: begin
					scroll_top   <= blk;
					scroll_start <= blk;
				end
				LRS_ASC_BOTTOM: scroll_bottom <= blk;
				LRS_ASC_COUNT:  scroll_count  <= blk;
				LRS_ASC_MODE:
					scroll_mode <= lrs_decode_mode(
						din_f[MODE_MSB:0]);
				LRS_SCS_BLOCK:  scroll_start <= blk;
				default:        scroll_start <= scroll_start;
			endcase
		end
	end

	// display line to block, range check
	logic [5:0] line_block;
	logic       in_disp;
	assign line_block = line_index[LINE_W-1:LINE_BLK_LSB];
	assign in_disp    = ~partial_active |
	                    ((line_block >= partial_start) &&
	                     (line_block <= partial_end));

	// display block to RAM block mapping
	logic [6:0] span;
	logic [6:0] scroll_raw;
	logic [6:0] scroll_wrap;
	logic [5:0] bottom_map;
	logic [5:0] next_ram_block;
	assign span        = {1'b0, scroll_bottom} - {1'b0, scroll_top}
	                     + ONE_BLOCK;
	assign scroll_raw  = {1'b0, scroll_start} + {1'b0, line_block}
	                     - {1'b0, scroll_top};
	assign scroll_wrap = (scroll_raw > {1'b0, scroll_bottom}) ?
	                     scroll_raw - span : scroll_raw;
	assign bottom_map  = LAST_RAM_BLOCK - (last_disp_block - line_block);
	assign next_ram_block =
		(line_block < scroll_top)   ? line_block :
		(line_block > scroll_count) ? bottom_map :
		scroll_wrap[BLK_W-1:0];

	// frame polarity and drive levels of non-display lines
	logic last_pol;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frame_polarity         <= 1'b0;
			last_pol               <= 1'b0;
			display_off_out_n      <= 1'b1;
			common_nonselect_level <= 1'b0;
			segment_pos_level      <= 1'b0;
			segment_neg_level      <= 1'b0;
			ram_block              <= RST_BLOCK;
		end else begin
			if (frame_start)
				frame_polarity <= ~frame_polarity;
			if (in_disp)
				last_pol <= frame_polarity;
			display_off_out_n      <= in_disp;
			common_nonselect_level <= ~in_disp;
			segment_pos_level      <= ~in_disp & last_pol;
			segment_neg_level      <= ~in_disp & ~last_pol;
			ram_block              <= next_ram_block;
		end
	end

endmodule

// *** lrs_host.sv ***
// host processor model driving the parallel command bus
`timescale 1ns/10ps
module lrs_host (
	// clock
	input  wire logic        clk,
	// bus pins toward the device
	output logic             cmd_data_select,
	output logic             wr_n,
	output logic             rd_n,
	output logic [15:0]      bus_din,
	// device read return
	input  wire logic [15:0] bus_dout,
	input  wire logic        bus_oe
);
	// idle bus, both strobes high
	initial begin
		cmd_data_select = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		bus_din = 16'h0000;
	end
	// one write cycle, select low for commands, high for data
	task automatic send(input logic sel, input logic [15:0] word);
		@(posedge clk);
		#2;
		cmd_data_select = sel;
		bus_din = word;
		wr_n = 1'b0;
		repeat (6) @(posedge clk);
		#2;
		wr_n = 1'b1;
		repeat (6) @(posedge clk);
		#2;
		bus_din = ~word; // released lines keep no stale value
	endtask
	// one read cycle, select high and write strobe idle
	task automatic fetch(output logic [15:0] word, output logic oe);
		@(posedge clk);
		#2;
		cmd_data_select = 1'b1;
		rd_n = 1'b0;
		oe = 1'b0;
		repeat (10) begin
			@(posedge clk);
			#1;
			oe = oe | bus_oe;
		end
		word = bus_dout;
		#1;
		rd_n = 1'b1;
		repeat (6) @(posedge clk);
		#2;
	endtask
endmodule

// *** lrs_cmd_core_properties.sv ***
// port assertions of the command block
`timescale 1ns/10ps
module lrs_cmd_props
	import lrs_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// watched ports
	input  wire logic              clock_source_select,
	input  wire logic              ram_we,
	input  wire logic              ram_re,
	input  wire logic              bus_oe,
	input  wire logic [ADDR_W-1:0] ram_page,
	input  wire logic [ADDR_W-1:0] ram_col,
	input  wire logic              frame_start,
	input  wire logic [LINE_W-1:0] line_index,
	input  wire logic              osc_enable,
	input  wire logic              partial_active,
	input  wire logic [BLK_W-1:0]  partial_start,
	input  wire logic [BLK_W-1:0]  partial_end,
	input  wire logic              display_off_out_n,
	input  wire logic              common_nonselect_level,
	input  wire logic              segment_pos_level,
	input  wire logic              segment_neg_level,
	input  wire logic              frame_polarity
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// steps of the watched behaviours
	sequence cls_low_s;
		!clock_source_select [*8];
	endsequence
	sequence re_pulse_s;
		ram_re ##1 !ram_re;
	endsequence
	chk_write_step: assert property (ram_we |=> !ram_we &&
		{ram_page, ram_col} != $past({ram_page, ram_col}))
		else $error("store pulse or address step wrong");
	chk_read_start: assert property ($rose(bus_oe) |-> re_pulse_s)
		else $error("bus drive without one read pulse");
	chk_osc_gated: assert property (cls_low_s |-> !$rose(osc_enable))
		else $error("oscillator started with external clock");
	chk_osc_hold: assert property (osc_enable |=> osc_enable)
		else $error("oscillator enable dropped");
	chk_polarity_flip: assert property (frame_polarity ==
		($past(frame_polarity) ^ $past(frame_start)))
		else $error("polarity not toggled per frame");
	chk_blank_drive: assert property (!display_off_out_n |->
		common_nonselect_level && (segment_pos_level ^ segment_neg_level))
		else $error("blank line drive levels wrong");
	chk_full_screen: assert property (!partial_active |=> display_off_out_n)
		else $error("line blanked outside partial mode");
	chk_partial_show: assert property (partial_active &&
		line_index[7:2] >= partial_start && line_index[7:2] <= partial_end
		|=> display_off_out_n)
		else $error("line inside partial range blanked");
	chk_partial_blank: assert property (partial_active &&
		line_index[7:2] > partial_end |=> !display_off_out_n)
		else $error("line past partial range shown");
endmodule

bind lrs_cmd_core lrs_cmd_props u_props (.clk(clk), .resetn(resetn),
	.clock_source_select(clock_source_select), .ram_we(ram_we),
	.ram_re(ram_re), .bus_oe(bus_oe), .ram_page(ram_page),
	.ram_col(ram_col), .frame_start(frame_start), .line_index(line_index),
	.osc_enable(osc_enable), .partial_active(partial_active),
	.partial_start(partial_start), .partial_end(partial_end),
	.display_off_out_n(display_off_out_n),
	.common_nonselect_level(common_nonselect_level),
	.segment_pos_level(segment_pos_level),
	.segment_neg_level(segment_neg_level), .frame_polarity(frame_polarity));

// *** tb.sv ***
// self-checking bench for the command block
`timescale 1ns/10ps
module tb;
	import lrs_pkg::*;
	// pins, display timing and outputs
	logic clk, resetn, cmd_data_select, wr_n, rd_n, bus_oe, ram_we, ram_re;
	logic clock_source_select, scan_page_dir, frame_start, osc_enable;
	logic partial_active, display_off_out_n, common_nonselect_level;
	logic segment_pos_level, segment_neg_level, frame_polarity, oe, pol;
	logic [15:0] bus_din, bus_dout, ram_wdata, ram_rdata, w;
	logic [7:0] ram_page, ram_col, line_index;
	logic [5:0] partial_start, partial_end, scroll_top, scroll_bottom;
	logic [5:0] scroll_count, scroll_start, ram_block;
	lrs_scroll_mode_t scroll_mode;
	logic [31:0] wq[$];
	int checks, n_mismatch;

	lrs_host host (.clk(clk), .cmd_data_select(cmd_data_select),
		.wr_n(wr_n), .rd_n(rd_n), .bus_din(bus_din), .bus_dout(bus_dout),
		.bus_oe(bus_oe));
	lrs_cmd_core uut (.clk(clk), .resetn(resetn),
		.cmd_data_select(cmd_data_select), .wr_n(wr_n), .rd_n(rd_n),
		.bus_din(bus_din), .bus_dout(bus_dout), .bus_oe(bus_oe),
		.clock_source_select(clock_source_select), .page_start(8'h02),
		.page_end(8'h03), .col_start(8'h05), .col_end(8'h06),
		.scan_page_dir(scan_page_dir), .ram_page(ram_page), .ram_col(ram_col),
		.ram_we(ram_we), .ram_wdata(ram_wdata), .ram_re(ram_re),
		.ram_rdata(ram_rdata), .frame_start(frame_start),
		.line_index(line_index), .last_disp_block(6'h1D),
		.osc_enable(osc_enable), .partial_active(partial_active),
		.partial_start(partial_start), .partial_end(partial_end),
		.display_off_out_n(display_off_out_n),
		.common_nonselect_level(common_nonselect_level),
		.segment_pos_level(segment_pos_level),
		.segment_neg_level(segment_neg_level),
		.frame_polarity(frame_polarity), .scroll_top(scroll_top),
		.scroll_bottom(scroll_bottom), .scroll_count(scroll_count),
		.scroll_mode(scroll_mode), .scroll_start(scroll_start),
		.ram_block(ram_block));

	// memory model returns its own address
	assign ram_rdata = {ram_page, ram_col};
	// clock
	always #25 clk = ~clk;
	// capture every memory store
	always @(posedge clk)
		if (ram_we === 1'b1)
			wq.push_back({ram_page, ram_col, ram_wdata});
	// frame start pulse every forty cycles
	initial forever begin
		repeat (39) @(posedge clk);
		#2 frame_start = 1'b1;
		@(posedge clk);
		#2 frame_start = 1'b0;
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// command with a junk upper byte, and data
	task automatic cmd(input logic [7:0] op);
		host.send(1'b0, {8'h5A, op});
	endtask
	task automatic dat(input logic [15:0] word);
		host.send(1'b1, word);
	endtask
	task automatic settle();
		repeat (3) @(posedge clk);
		#2;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic t_write();
		scan_page_dir = 1'b1;
		wq.delete();
		cmd(OPC_MEMORY_WRITE);
		for (int k = 1; k < 4; k++)
			dat(16'(k) * 16'h1111);
		cmd(OPC_PARTIAL_EXIT);
		dat(16'hBEEF);
		chk("store count", 3, wq.size());
		chk("store 1", 32'h0205_1111, wq[0]);
		chk("store 2", 32'h0305_2222, wq[1]);
		chk("store 3", 32'h0206_3333, wq[2]);
		$display("test write done");
	endtask
	task automatic t_read();
		scan_page_dir = 1'b0;
		cmd(OPC_MEMORY_READ);
		host.fetch(w, oe);
		chk("read 1", 32'h0205, w);
		host.fetch(w, oe);
		chk("read 2", 32'h0206, w);
		chk("read drive", 1, oe);
		cmd(OPC_OSCILLATOR_ON);
		chk("osc external", 0, osc_enable);
		host.fetch(w, oe);
		chk("read after cmd", 0, oe);
		$display("test read done");
	endtask
	task automatic t_rmw();
		scan_page_dir = 1'b1;
		cmd(OPC_RMW_ENTER);
		host.fetch(w, oe);
		chk("rmw read 1", 32'h0205, w);
		host.fetch(w, oe);
		chk("rmw read 2", 32'h0205, w);
		wq.delete();
		dat(16'hA5A5);
		chk("rmw store", 32'h0205_A5A5, wq[0]);
		host.fetch(w, oe);
		chk("rmw read 3", 32'h0305, w);
		cmd(OPC_RMW_EXIT);
		host.fetch(w, oe);
		chk("rmw ended", 0, oe);
		$display("test rmw done");
	endtask
	task automatic t_partial();
		cmd(OPC_PARTIAL_ENTER);
		dat(16'hFFC3);
		dat(16'h0005);
		chk("partial on", 1, partial_active);
		chk("partial range", 32'h00C5, {partial_start, partial_end});
		line_index = 8'd23;
		settle();
		chk("shown line", 2'b10, {display_off_out_n, common_nonselect_level});
		// polarity held over the last shown line picks the blank level
		pol = frame_polarity;
		@(posedge clk);
		#2 line_index = 8'd24;
		settle();
		chk("blank line", 2'b01, {display_off_out_n, common_nonselect_level});
		chk("blank segment", {pol, ~pol}, {segment_pos_level, segment_neg_level});
		cmd(OPC_PARTIAL_EXIT);
		line_index = 8'd24;
		settle();
		chk("full screen", 2'b01, {partial_active, display_off_out_n});
		$display("test partial done");
	endtask
	task automatic t_scroll();
		// top and whole scroll start at block 0, bottom and whole end at 32
		for (int m = 3; m >= 0; m--) begin
			cmd(OPC_AREA_SCROLL);
			dat(m[0] ? 16'hFF00 : 16'hFF02);
			dat(m[1] ? 16'h0020 : 16'h001E);
			dat(m[1] ? 16'h0020 : 16'h001B);
			dat(16'hFFFC | 16'(m));
			chk("scroll mode", m, scroll_mode);
		end
		chk("scroll top", 2, scroll_top);
		chk("scroll bottom", 30, scroll_bottom);
		chk("scroll count", 27, scroll_count);
		chk("scroll first", 2, scroll_start);
		cmd(OPC_SCROLL_START);
		dat(16'hC007);
		chk("scroll start", 7, scroll_start);
		line_index = 8'd4;
		settle();
		chk("top fixed block", 1, ram_block);
		line_index = 8'd8;
		settle();
		chk("scroll first block", 7, ram_block);
		line_index = 8'd116;
		settle();
		chk("bottom fixed block", 41, ram_block);
		$display("test scroll done");
	endtask
	task automatic t_osc();
		clock_source_select = 1'b1;
		cmd(OPC_OSCILLATOR_ON);
		settle();
		chk("osc internal", 1, osc_enable);
		$display("test osc done");
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("BAD watchdog expected 0 seen 1");
		close_out();
	end
	// main sequence
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		clock_source_select = 1'b0;
		scan_page_dir = 1'b0;
		frame_start = 1'b0;
		line_index = 8'h00;
		repeat (10) @(posedge clk);
		#2 resetn = 1'b1;
		t_write();
		t_read();
		t_rmw();
		t_partial();
		t_scroll();
		t_osc();
		close_out();
	end
endmodule
